// File: src/adcc_cfg.svh
// constants and register map of the converter control block
// Contract
// - a result read colliding with result update completes first, update follows
// - config write colliding with result update wins; result and irq dropped
// - writing channel select never clears the conversion end flag
// - result for old channel may land just before a channel change
// - config writes may drop a new result; software reads result first
// - results are 10 bits, all carried to software
// - result failing the window compare (outside, or inside when range select is set) is not stored
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH
`define ADCC_OFF_MODE0 8'h00
`define ADCC_OFF_CHSEL 8'h04
`define ADCC_OFF_PORTCFG 8'h08
`define ADCC_OFF_PMC 8'h0C
`define ADCC_OFF_RESULT 8'h10
`define ADCC_OFF_RESULTH 8'h14
`define ADCC_OFF_IRQSTAT 8'h18
`define ADCC_OFF_IRQMASK 8'h1C
`define ADCC_OFF_UPPER 8'h20
`define ADCC_OFF_LOWER 8'h24
`define ADCC_OFF_RANGE 8'h28
`define ADCC_OFF_STATUS 8'h2C
`define ADCC_BIT_RUN 7
`define ADCC_BIT_POWER 0
`define ADCC_BIT_ENDFLAG 0
`define ADCC_BIT_FIRSTBAD 1
`define ADCC_RES_W 10
`define ADCC_CONV_CYCLES 8'h14
`define ADCC_PWR_WAIT_NS 1000
`define ADCC_CLK_NS 100
`define ADCC_PWR_WAIT_CYC ((`ADCC_PWR_WAIT_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`define ADCC_RESP_OKAY 2'h0
`define ADCC_RESP_SLVERR 2'h2
`endif

// File: src/adcc_pkg.sv
// types of the converter control block
package adcc_pkg;
    typedef enum logic [1:0] {CONV_IDLE, CONV_RUN, CONV_DONE} adcc_conv_t;
    typedef struct packed {
        logic [1:0] rstSync;
        logic [7:0] mode0;
        logic [7:0] chSel;
        logic [7:0] portCfg;
        logic [7:0] port_mode_control_reg;
        logic [9:0] result;
        logic [1:0] irqStat;
        logic [1:0] irqMask;
        logic [9:0] upper;
        logic [9:0] lower;
        logic rangeSel;
        adcc_conv_t conv;
        logic [7:0] convCnt;
        logic [9:0] sample;
        logic [7:0] pwrCnt;
        logic firstConv;
        logic firstBad;
        logic pendUpd;
        logic awPend;
        logic [7:0] awAddr;
        logic wPend;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic rdResult;
    } adcc_state_t;
endpackage

// File: src/adcc_control.sv
// converter control logic with axi4-lite register slave
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "adcc_cfg.svh"
module adcc_control
    import adcc_pkg::*;
#(
    parameter int ResW = `ADCC_RES_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // axi4-lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // analog core
    input wire logic [ResW-1:0] sampleIn,
    output logic [7:0] analogChannel,
    output logic converterPowered,
    // interrupt
    output logic conversionEndIrq
);
    adcc_state_t s_reg, s_next;
    logic rstInt_n;
    logic wrFire, rdFire, rdIsResult, cfgWrite, inWindow, updNow;
    logic [31:0] rdVal;

    assign rstInt_n = s_reg.rstSync[1];

    function automatic logic [7:0] put8(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] st);
        put8 = st[0] ? d[7:0] : old;
    endfunction

    function automatic logic [9:0] put10(input logic [9:0] old, input logic [31:0] d,
                                         input logic [3:0] st);
        logic [9:0] v;
        v = old;
        if (st[0]) begin
            v[7:0] = d[7:0];
        end
        if (st[1]) begin
            v[9:8] = d[9:8];
        end
        put10 = v;
    endfunction

    always_comb begin
        rdVal = 32'h0000_0000;
        case (araddr)
            `ADCC_OFF_MODE0: rdVal = {24'h00_0000, s_reg.mode0};
            `ADCC_OFF_CHSEL: rdVal = {24'h00_0000, s_reg.chSel};
            `ADCC_OFF_PORTCFG: rdVal = {24'h00_0000, s_reg.portCfg};
            `ADCC_OFF_PMC: rdVal = {24'h00_0000, s_reg.port_mode_control_reg};
            `ADCC_OFF_RESULT: rdVal = {22'h00_0000, s_reg.result};
            `ADCC_OFF_RESULTH: rdVal = {24'h00_0000, s_reg.result[9:2]};
            `ADCC_OFF_IRQSTAT: rdVal = {30'h0000_0000, s_reg.irqStat};
            `ADCC_OFF_IRQMASK: rdVal = {30'h0000_0000, s_reg.irqMask};
            `ADCC_OFF_UPPER: rdVal = {22'h00_0000, s_reg.upper};
            `ADCC_OFF_LOWER: rdVal = {22'h00_0000, s_reg.lower};
            `ADCC_OFF_RANGE: rdVal = {31'h0000_0000, s_reg.rangeSel};
            `ADCC_OFF_STATUS: rdVal = {29'h0000_0000, s_reg.firstBad,
                                       s_reg.conv == CONV_RUN, s_reg.firstConv};
            default: rdVal = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_next = s_reg;
        s_next.rstSync = {s_reg.rstSync[0], 1'b1};
        awready = !s_reg.awPend && !s_reg.bValid;
        wready = !s_reg.wPend && !s_reg.bValid;
        arready = !s_reg.rValid;
        rdFire = arvalid && arready;
        rdIsResult = rdFire && (araddr == `ADCC_OFF_RESULT || araddr == `ADCC_OFF_RESULTH);
        wrFire = s_reg.awPend && s_reg.wPend && !s_reg.bValid;
        cfgWrite = wrFire && s_reg.wStrb[0] &&
                   (s_reg.awAddr == `ADCC_OFF_MODE0 || s_reg.awAddr == `ADCC_OFF_CHSEL ||
                    s_reg.awAddr == `ADCC_OFF_PORTCFG);
        // window check: results failing the compare (outside, or inside when rangeSel is set) neither store nor interrupt
        inWindow = s_reg.rangeSel ?
                   (s_reg.sample > s_reg.upper || s_reg.sample < s_reg.lower) :
                   (s_reg.sample <= s_reg.upper && s_reg.sample >= s_reg.lower);
        updNow = 1'b0;

        if (awvalid && awready) begin
            s_next.awPend = 1'b1;
            s_next.awAddr = awaddr;
        end
        if (wvalid && wready) begin
            s_next.wPend = 1'b1;
            s_next.wData = wdata;
            s_next.wStrb = wstrb;
        end
        if (s_reg.bValid && bready) begin
            s_next.bValid = 1'b0;
        end
        if (s_reg.rValid && rready) begin
            s_next.rValid = 1'b0;
        end
        if (rdFire) begin
            s_next.rValid = 1'b1;
            s_next.rData = rdVal;
            s_next.rResp = (araddr[1:0] != 2'h0 || araddr > `ADCC_OFF_STATUS) ?
                           `ADCC_RESP_SLVERR : `ADCC_RESP_OKAY;
        end

        // conversion sequencer
        case (s_reg.conv)
            CONV_IDLE: begin
                if (s_reg.mode0[`ADCC_BIT_RUN] && s_reg.mode0[`ADCC_BIT_POWER]) begin
                    s_next.conv = CONV_RUN;
                    s_next.convCnt = `ADCC_CONV_CYCLES;
                end
            end
            CONV_RUN: begin
                if (!s_reg.mode0[`ADCC_BIT_RUN] || !s_reg.mode0[`ADCC_BIT_POWER]) begin
                    s_next.conv = CONV_IDLE;
                end else if (s_reg.convCnt == 8'h01) begin
                    // a channel write mid-run does not abort, so the old input still lands
                    s_next.sample = sampleIn;
                    s_next.conv = CONV_DONE;
                end else begin
                    s_next.convCnt = s_reg.convCnt - 8'h01;
                end
            end
            CONV_DONE: begin
                // a result read in this cycle goes first; update waits one cycle
                if (cfgWrite) begin
                    s_next.pendUpd = 1'b0;
                end else if (rdIsResult) begin
                    s_next.pendUpd = 1'b1;
                end else begin
                    // a deferred update is taken here once, never again after leaving
                    s_next.pendUpd = 1'b0;
                    updNow = inWindow;
                end
                if (!rdIsResult || cfgWrite) begin
                    s_next.conv = s_reg.mode0[`ADCC_BIT_RUN] ? CONV_RUN : CONV_IDLE;
                    s_next.convCnt = `ADCC_CONV_CYCLES;
                end
            end
            default: s_next.conv = CONV_IDLE;
        endcase
        if (s_reg.pendUpd && s_reg.conv != CONV_DONE) begin
            s_next.pendUpd = 1'b0;
            updNow = inWindow && !cfgWrite;
        end
        if (updNow) begin
            s_next.result = s_reg.sample;
            s_next.firstBad = s_reg.firstConv;
            s_next.firstConv = 1'b0;
        end

        // power-on settle timer marks a too-early first result
        if (!s_reg.mode0[`ADCC_BIT_POWER]) begin
            s_next.pwrCnt = 8'(`ADCC_PWR_WAIT_CYC);
            s_next.firstConv = 1'b0;
        end else if (s_reg.pwrCnt != 8'h00) begin
            s_next.pwrCnt = s_reg.pwrCnt - 8'h01;
            if (s_reg.mode0[`ADCC_BIT_RUN]) begin
                s_next.firstConv = 1'b1;
            end
        end

        if (wrFire) begin
            s_next.awPend = 1'b0;
            s_next.wPend = 1'b0;
            s_next.bValid = 1'b1;
            s_next.bResp = `ADCC_RESP_OKAY;
            case (s_reg.awAddr)
                `ADCC_OFF_MODE0: s_next.mode0 = put8(s_reg.mode0, s_reg.wData, s_reg.wStrb);
                // channel change leaves the end flag alone
                `ADCC_OFF_CHSEL: s_next.chSel = put8(s_reg.chSel, s_reg.wData, s_reg.wStrb);
                `ADCC_OFF_PORTCFG: s_next.portCfg = put8(s_reg.portCfg, s_reg.wData, s_reg.wStrb);
                `ADCC_OFF_PMC: s_next.port_mode_control_reg = put8(s_reg.port_mode_control_reg, s_reg.wData, s_reg.wStrb);
                `ADCC_OFF_IRQSTAT: begin
                    if (s_reg.wStrb[0]) begin
                        s_next.irqStat = s_reg.irqStat & ~s_reg.wData[1:0];
                    end
                end
                `ADCC_OFF_IRQMASK: begin
                    if (s_reg.wStrb[0]) begin
                        s_next.irqMask = s_reg.wData[1:0];
                    end
                end
                `ADCC_OFF_UPPER: s_next.upper = put10(s_reg.upper, s_reg.wData, s_reg.wStrb);
                `ADCC_OFF_LOWER: s_next.lower = put10(s_reg.lower, s_reg.wData, s_reg.wStrb);
                `ADCC_OFF_RANGE: begin
                    if (s_reg.wStrb[0]) begin
                        s_next.rangeSel = s_reg.wData[0];
                    end
                end
                `ADCC_OFF_RESULT, `ADCC_OFF_RESULTH, `ADCC_OFF_STATUS: begin
                end
                default: s_next.bResp = `ADCC_RESP_SLVERR;
            endcase
        end
        // set wins over a clear in the same cycle
        if (updNow) begin
            s_next.irqStat[`ADCC_BIT_ENDFLAG] = 1'b1;
            if (s_reg.firstConv) begin
                s_next.irqStat[`ADCC_BIT_FIRSTBAD] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else if (!rstInt_n) begin
            s_reg <= '0;
            s_reg.rstSync <= s_next.rstSync;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bvalid = s_reg.bValid;
    assign bresp = s_reg.bResp;
    assign rvalid = s_reg.rValid;
    assign rdata = s_reg.rData;
    assign rresp = s_reg.rResp;
    assign analogChannel = s_reg.chSel;
    assign converterPowered = s_reg.mode0[`ADCC_BIT_POWER];
    assign conversionEndIrq = |(s_reg.irqStat & s_reg.irqMask);
endmodule
`default_nettype wire

// File: test/adcc_control_assertions.sv
// port checks of the converter control block
`timescale 1ns/10ps
`default_nettype none
module adcc_control_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    // converter side
    input wire logic [7:0] analogChannel,
    input wire logic converterPowered,
    input wire logic conversionEndIrq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence wrTaken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence wrAnswer;
        !bvalid ##1 bvalid;
    endsequence
    ////////////////////////////////////////////////////////////////
    write_answer_a: assert property (wrTaken |=> wrAnswer)
        else $error("write response not two cycles after transfer");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    read_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    read_block_a: assert property (arready == !rvalid)
        else $error("read address accepted while answer pending");
    write_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while response pending");
    irq_sticky_a: assert property ($fell(conversionEndIrq) |-> bvalid)
        else $error("interrupt fell without a register write");
    chan_write_a: assert property ($changed(analogChannel) |-> bvalid || $past(bvalid))
        else $error("channel changed without a write");
    power_write_a: assert property ($changed(converterPowered) |-> bvalid || $past(bvalid))
        else $error("power enable changed without a write");
endmodule
bind adcc_control adcc_control_assertions i_chk (.clk(clk), .rst_n(rst_n),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .analogChannel(analogChannel),
    .converterPowered(converterPowered), .conversionEndIrq(conversionEndIrq));
`default_nettype wire

// File: test/adcc_control_bench.sv
// self-checking bench of the converter control block
`timescale 1ns/10ps
`default_nettype none
module adcc_control_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [9:0] sampleIn = 10'h000;
    logic awready, wready, bvalid, arready, rvalid, converterPowered, conversionEndIrq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] analogChannel;
    int failures = 0;
    int num_checks = 0;
    always #50 clk = ~clk;
    adcc_control i_dut (.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .sampleIn(sampleIn), .analogChannel(analogChannel),
        .converterPowered(converterPowered), .conversionEndIrq(conversionEndIrq));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // both channels offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done, aw, w;
        logic [1:0] r;
        @(posedge clk);
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 40 && !done; i++) begin
            @(negedge clk);
            aw = awvalid && awready;
            w = wvalid && wready;
            done = bvalid;
            r = bresp;
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic done, ar;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 40 && !done; i++) begin
            @(negedge clk);
            ar = arvalid && arready;
            done = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
        chk(d, exp);
    endtask
    // settled level of the interrupt, waiting at most n cycles for it
    task automatic irqChk(input logic exp, input int n);
        for (int i = 0; i < n && conversionEndIrq !== exp; i++) @(negedge clk);
        @(negedge clk);
        chk({31'h0, conversionEndIrq}, {31'h0, exp});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h18, 32'h0, 2'h0);
        rd(8'h30, 32'h0, 2'h2);
        wr(8'h31, 32'h1, 2'h2);
        wr(8'h10, 32'h3FF, 2'h0);
        rd(8'h10, 32'h0, 2'h0);
        wr(8'h20, 32'h3FF, 2'h0);
        wr(8'h1C, 32'h1, 2'h0);
        wr(8'h00, 32'h01, 2'h0);
        sampleIn <= 10'h2A5;
        chk({31'h0, converterPowered}, 32'h1);
        repeat (12) @(posedge clk);
        wr(8'h00, 32'h81, 2'h0);
        irqChk(1'b1, 60);
        wr(8'h00, 32'h01, 2'h0);
        rd(8'h10, 32'h2A5, 2'h0);
        rd(8'h14, 32'hA9, 2'h0);
        rd(8'h18, 32'h1, 2'h0);
        wr(8'h04, 32'h3, 2'h0);
        chk({24'h0, analogChannel}, 32'h3);
        rd(8'h18, 32'h1, 2'h0);
        wr(8'h1C, 32'h0, 2'h0);
        irqChk(1'b0, 0);
        wr(8'h1C, 32'h1, 2'h0);
        irqChk(1'b1, 0);
        wr(8'h18, 32'h1, 2'h0);
        irqChk(1'b0, 0);
        // sample above a narrow window is dropped, then kept once outside is chosen
        wr(8'h20, 32'h100, 2'h0);
        sampleIn <= 10'h155;
        wr(8'h00, 32'h81, 2'h0);
        repeat (60) @(posedge clk);
        irqChk(1'b0, 0);
        wr(8'h00, 32'h01, 2'h0);
        rd(8'h10, 32'h2A5, 2'h0);
        wr(8'h28, 32'h1, 2'h0);
        wr(8'h00, 32'h81, 2'h0);
        irqChk(1'b1, 60);
        wr(8'h00, 32'h01, 2'h0);
        rd(8'h10, 32'h155, 2'h0);
        // power and run together: first result flagged as suspect
        wr(8'h18, 32'h3, 2'h0);
        wr(8'h00, 32'h00, 2'h0);
        wr(8'h00, 32'h81, 2'h0);
        irqChk(1'b1, 80);
        wr(8'h00, 32'h00, 2'h0);
        rd(8'h18, 32'h3, 2'h0);
        conclude();
    end
    initial begin
        #2000000;
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
